// ### design/dsr_pkg.sv
package dsr_pkg;
	localparam int ADDR_W = 7;
	localparam int IDX_W = 5;
	// printed offsets are register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_CTRL_TWO = 5'h06;
	localparam logic [IDX_W-1:0] IDX_RSVD_SEVEN = 5'h07;
	localparam logic [IDX_W-1:0] IDX_RSVD_EIGHT = 5'h08;
	localparam logic [IDX_W-1:0] IDX_SRATE = 5'h09;
	localparam logic [IDX_W-1:0] IDX_RSVD_TEN = 5'h0a;
	localparam logic [IDX_W-1:0] IDX_SYS_REV = 5'h0b;
	localparam logic [IDX_W-1:0] IDX_LINE_STAT = 5'h0c;
	localparam logic [IDX_W-1:0] IDX_LINE_REV = 5'h0d;
	localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 5'h10;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 5'h11;
	localparam logic [7:0] CTRL_TWO_RST = 8'h70;
	localparam logic [7:0] CTRL_TWO_WMASK = 8'h7b;
	localparam logic [2:0] SRATE_RST = 3'h0;
	localparam logic [1:0] IRQ_MASK_RST = 2'h0;
	localparam int CT_TX_HI = 6;
	localparam int CT_TX_LO = 1;
	localparam int CT_RX_HI = 5;
	localparam int CT_RX_LO = 0;
	localparam int CT_LINE_PD = 4;
	localparam int CT_SYS_PD = 3;
	localparam int LS_ERR_BIT = 7;
	localparam int LR_RXB_BIT = 1;
	localparam int LR_TXB_BIT = 0;
	localparam int IRQ_LINK_ERR = 0;
	localparam int IRQ_LOCK_CHG = 1;
	localparam int IRQ_W = 2;
	// packing of the synchronised side-band inputs
	localparam int SY_W = 13;
	localparam int SY_LINK = 12;
	localparam int SY_LOCK = 11;
	localparam int SY_HOOK = 10;
	localparam int SY_CAP = 9;
	localparam int SY_SENSE_LO = 4;
	localparam int SY_REV_LO = 0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [5:0] TX_DB_00 = 6'h1a;
	localparam logic [5:0] TX_DB_01 = 6'h14;
	localparam logic [5:0] TX_DB_11 = 6'h20;
	localparam logic [5:0] RX_DB_00 = 6'h06;
	localparam logic [5:0] RX_DB_01 = 6'h00;
	localparam logic [5:0] RX_DB_11 = 6'h0c;
	localparam logic [13:0] RATE_HZ_0 = 14'h1c20;
	localparam logic [13:0] RATE_HZ_1 = 14'h1f40;
	localparam logic [13:0] RATE_HZ_2 = 14'h2025;
	localparam logic [13:0] RATE_HZ_3 = 14'h20d0;
	localparam logic [13:0] RATE_HZ_4 = 14'h2328;
	localparam logic [13:0] RATE_HZ_5 = 14'h2580;
	localparam logic [13:0] RATE_HZ_6 = 14'h282e;

	// returns {mute, attenuation in dB}
	function automatic logic [6:0] cp_level(input logic [1:0] sel, input logic is_tx);
		unique case (sel)
			2'h0: return {1'b0, is_tx ? TX_DB_00 : RX_DB_00};
			2'h1: return {1'b0, is_tx ? TX_DB_01 : RX_DB_01};
			2'h2: return 7'h40;
			2'h3: return {1'b0, is_tx ? TX_DB_11 : RX_DB_11};
		endcase
	endfunction

	// reserved code yields zero so downstream clocking can refuse it
	function automatic logic [13:0] rate_hz(input logic [2:0] code);
		unique case (code)
			3'h0: return RATE_HZ_0;
			3'h1: return RATE_HZ_1;
			3'h2: return RATE_HZ_2;
			3'h3: return RATE_HZ_3;
			3'h4: return RATE_HZ_4;
			3'h5: return RATE_HZ_5;
			3'h6: return RATE_HZ_6;
			3'h7: return 14'h0;
		endcase
	endfunction

	function automatic logic [3:0] loop_decode(input logic [4:0] code, input logic hook);
		if (hook && code == 5'h1e) return 4'he;
		if (hook && code == 5'h01) return 4'h1;
		return code[4:1];
	endfunction
endpackage

// ### design/dsr_regs.sv
`timescale 1ns/1ns
`default_nettype none

module dsr_regs #(
	// arbitrary value, replaced per silicon revision
	parameter logic [3:0] SYS_REV_CODE = 4'h1
) (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic [dsr_pkg::ADDR_W-1:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [dsr_pkg::ADDR_W-1:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic link_fail_in,
	input wire logic frame_lock_in,
	input wire logic off_hook_in,
	input wire logic line_capability_in,
	input wire logic [4:0] line_sense_code_in,
	input wire logic [3:0] line_rev_code_in,
	output logic cp_tx_mute_out,
	output logic [5:0] cp_tx_atten_db_out,
	output logic cp_rx_mute_out,
	output logic [5:0] cp_rx_atten_db_out,
	output logic line_chip_powerdown_out,
	output logic system_module_powerdown_out,
	output logic [2:0] sample_rate_sel_out,
	output logic [13:0] sample_rate_hz_out,
	output logic legacy_rx_boost_out,
	output logic legacy_tx_atten_out,
	output logic irq_out
);
	import dsr_pkg::*;

	typedef struct packed {
		logic [7:0] ctrl_two;
		logic [2:0] srate;
		logic rxb;
		logic txb;
		logic link_err;
		logic sys_pd;
		logic [SY_W-1:0] sync1;
		logic [SY_W-1:0] sync2;
		logic lock_prev;
		logic [IRQ_W-1:0] irq_stat;
		logic [IRQ_W-1:0] irq_mask;
		logic aw_have;
		logic [IDX_W-1:0] aw_idx;
		logic w_have;
		logic [7:0] w_byte;
		logic w_lane;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [7:0] rdata;
		logic [1:0] rresp;
		logic [IDX_W-1:0] rd_idx;
		logic tx_mute;
		logic [5:0] tx_db;
		logic rx_mute;
		logic [5:0] rx_db;
		logic [13:0] rate;
		logic irq;
	} dsr_state_t;

	dsr_state_t q;
	dsr_state_t d;
	logic wr_fire;
	logic wr_en;
	logic rd_fire;
	logic [IDX_W-1:0] ar_idx;

	function automatic logic idx_mapped(input logic [IDX_W-1:0] idx);
		return (idx >= IDX_CTRL_TWO && idx <= IDX_LINE_REV) ||
			idx == IDX_IRQ_STAT || idx == IDX_IRQ_MASK;
	endfunction

	function automatic logic [7:0] read_reg(input logic [IDX_W-1:0] idx, input dsr_state_t s);
		unique case (idx)
			IDX_CTRL_TWO: return s.ctrl_two & CTRL_TWO_WMASK;
			IDX_SRATE: return {5'h00, s.srate};
			IDX_SYS_REV: return {4'h0, SYS_REV_CODE};
			IDX_LINE_STAT: return {s.link_err, s.sync2[SY_LOCK], 2'h0,
				loop_decode(s.sync2[SY_SENSE_LO +: 5], s.sync2[SY_HOOK])};
			IDX_LINE_REV: return {1'b0, s.sync2[SY_CAP], s.sync2[SY_REV_LO +: 4], s.rxb, s.txb};
			IDX_IRQ_STAT: return {6'h00, s.irq_stat};
			IDX_IRQ_MASK: return {6'h00, s.irq_mask};
			default: return 8'h00;
		endcase
	endfunction

	assign ar_idx = s_axi_araddr_in[ADDR_W-1:2];

	always_comb begin
		d = q;
		d.sync1 = {link_fail_in, frame_lock_in, off_hook_in, line_capability_in,
			line_sense_code_in, line_rev_code_in};
		d.sync2 = q.sync1;
		d.lock_prev = q.sync2[SY_LOCK];

		// write address and data are taken independently, then joined
		wr_fire = q.aw_have && q.w_have && !q.bvalid;
		wr_en = wr_fire && q.w_lane && idx_mapped(q.aw_idx);
		if (q.bvalid && s_axi_bready_in) begin
			d.bvalid = 1'b0;
		end
		if (wr_fire) begin
			d.aw_have = 1'b0;
			d.w_have = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = idx_mapped(q.aw_idx) ? RESP_OKAY : RESP_SLVERR;
		end
		if (s_axi_awvalid_in && q.awready) begin
			d.aw_have = 1'b1;
			d.aw_idx = s_axi_awaddr_in[ADDR_W-1:2];
		end
		if (s_axi_wvalid_in && q.wready) begin
			d.w_have = 1'b1;
			d.w_byte = s_axi_wdata_in[7:0];
			d.w_lane = s_axi_wstrb_in[0];
		end
		d.awready = !d.aw_have && !d.bvalid;
		d.wready = !d.w_have && !d.bvalid;

		if (wr_en) begin
			unique case (q.aw_idx)
				IDX_CTRL_TWO: d.ctrl_two = q.w_byte & CTRL_TWO_WMASK;
				IDX_SRATE: d.srate = q.w_byte[2:0];
				IDX_LINE_REV: begin
					d.rxb = q.w_byte[LR_RXB_BIT];
					d.txb = q.w_byte[LR_TXB_BIT];
				end
				IDX_IRQ_MASK: d.irq_mask = q.w_byte[IRQ_W-1:0];
				default: begin
				end
			endcase
		end
		if (wr_en && q.aw_idx == IDX_LINE_STAT && !q.w_byte[LS_ERR_BIT]) begin
			d.link_err = 1'b0;
		end
		// link failure sets the flag, winning over a clear
		if (q.sync2[SY_LINK]) begin
			d.link_err = 1'b1;
		end
		// latch powerdown; clearing the bit cannot wake the module
		if (q.ctrl_two[CT_SYS_PD]) begin
			d.sys_pd = 1'b1;
		end

		rd_fire = s_axi_arvalid_in && q.arready;
		if (q.rvalid && s_axi_rready_in) begin
			d.rvalid = 1'b0;
		end
		if (rd_fire) begin
			d.rvalid = 1'b1;
			d.rd_idx = ar_idx;
			d.rdata = read_reg(ar_idx, q);
			d.rresp = idx_mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
		end
		d.arready = !d.rvalid;

		// reading status clears it; an event in the same cycle still lands
		if (rd_fire && ar_idx == IDX_IRQ_STAT) begin
			d.irq_stat = '0;
		end
		if (q.sync2[SY_LINK] && !q.link_err) begin
			d.irq_stat[IRQ_LINK_ERR] = 1'b1;
		end
		if (q.sync2[SY_LOCK] != q.lock_prev) begin
			d.irq_stat[IRQ_LOCK_CHG] = 1'b1;
		end
		d.irq = |(d.irq_stat & d.irq_mask);

		{d.tx_mute, d.tx_db} = cp_level({d.ctrl_two[CT_TX_HI], d.ctrl_two[CT_TX_LO]}, 1'b1);
		{d.rx_mute, d.rx_db} = cp_level({d.ctrl_two[CT_RX_HI], d.ctrl_two[CT_RX_LO]}, 1'b0);
		d.rate = rate_hz(d.srate);
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			q <= '0;
			q.ctrl_two <= CTRL_TWO_RST;
			q.srate <= SRATE_RST;
			q.irq_mask <= IRQ_MASK_RST;
			q.awready <= 1'b1;
			q.wready <= 1'b1;
			q.arready <= 1'b1;
			q.tx_mute <= 1'b1;
			q.rx_mute <= 1'b1;
			q.rate <= RATE_HZ_0;
		end else begin
			q <= d;
		end
	end

	assign s_axi_awready_out = q.awready;
	assign s_axi_wready_out = q.wready;
	assign s_axi_bvalid_out = q.bvalid;
	assign s_axi_bresp_out = q.bresp;
	assign s_axi_arready_out = q.arready;
	assign s_axi_rvalid_out = q.rvalid;
	assign s_axi_rdata_out = {24'h00_0000, q.rdata};
	assign s_axi_rresp_out = q.rresp;
	assign cp_tx_mute_out = q.tx_mute;
	assign cp_tx_atten_db_out = q.tx_db;
	assign cp_rx_mute_out = q.rx_mute;
	assign cp_rx_atten_db_out = q.rx_db;
	assign line_chip_powerdown_out = q.ctrl_two[CT_LINE_PD];
	assign system_module_powerdown_out = q.sys_pd;
	assign sample_rate_sel_out = q.srate;
	assign sample_rate_hz_out = q.rate;
	assign legacy_rx_boost_out = q.rxb;
	assign legacy_tx_atten_out = q.txb;
	assign irq_out = q.irq;

	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!rst_n_in);

	sequence s_ctrl_write;
		wr_en && q.aw_idx == IDX_CTRL_TWO;
	endsequence

	sequence s_err_clear;
		wr_en && q.aw_idx == IDX_LINE_STAT && !q.w_byte[LS_ERR_BIT];
	endsequence

	sequence s_line_rev_read;
		rd_fire && ar_idx == IDX_LINE_REV;
	endsequence

	sequence s_line_rev_write;
		wr_en && q.aw_idx == IDX_LINE_REV;
	endsequence

	a_tx_level_map: assert property (s_ctrl_write |=> {cp_tx_mute_out, cp_tx_atten_db_out} ==
		cp_level({$past(q.w_byte[CT_TX_HI]), $past(q.w_byte[CT_TX_LO])}, 1'b1))
		else $error("tx call-progress level wrong after write");
	a_rx_level_map: assert property (s_ctrl_write |=> {cp_rx_mute_out, cp_rx_atten_db_out} ==
		cp_level({$past(q.w_byte[CT_RX_HI]), $past(q.w_byte[CT_RX_LO])}, 1'b0))
		else $error("rx call-progress level wrong after write");
	a_line_pd_write: assert property (s_ctrl_write |=>
		line_chip_powerdown_out == $past(q.w_byte[CT_LINE_PD]))
		else $error("line chip powerdown not following write");
	a_sys_pd_sticky: assert property (system_module_powerdown_out |=>
		system_module_powerdown_out)
		else $error("system powerdown released without reset");
	a_sys_pd_entry: assert property (s_ctrl_write ##1 q.ctrl_two[CT_SYS_PD] |=>
		system_module_powerdown_out)
		else $error("system powerdown not entered");
	a_rsvd_read_zero: assert property (rd_fire && (ar_idx == IDX_RSVD_SEVEN ||
		ar_idx == IDX_RSVD_EIGHT || ar_idx == IDX_RSVD_TEN) |=> s_axi_rdata_out == 32'h0000_0000)
		else $error("reserved register read nonzero");
	a_rsvd_bits_zero: assert property (rd_fire && ar_idx == IDX_LINE_STAT |=>
		s_axi_rdata_out[5:4] == 2'h0 && s_axi_rdata_out[31:8] == 24'h00_0000)
		else $error("reserved status bits read nonzero");
	a_rate_decode: assert property (wr_en && q.aw_idx == IDX_SRATE |=>
		sample_rate_hz_out == rate_hz($past(q.w_byte[2:0])))
		else $error("sample rate decode wrong");
	a_link_err_set: assert property (q.sync2[SY_LINK] |=> q.link_err ##1 (q.link_err ||
		$past(wr_en && q.aw_idx == IDX_LINE_STAT && !q.w_byte[LS_ERR_BIT])))
		else $error("link error flag not set by failure");
	a_link_err_hold: assert property (q.link_err &&
		!(wr_en && q.aw_idx == IDX_LINE_STAT && !q.w_byte[LS_ERR_BIT]) |=> q.link_err)
		else $error("link error flag dropped without write of zero");
	a_link_err_clear: assert property (s_err_clear ##0 !q.sync2[SY_LINK] |=>
		!q.link_err)
		else $error("link error flag not cleared by write of zero");
	a_lock_read: assert property (rd_fire && ar_idx == IDX_LINE_STAT |=>
		s_axi_rdata_out[6] == $past(q.sync2[SY_LOCK]))
		else $error("frame lock bit mismatch");
	a_loop_decode: assert property (rd_fire && ar_idx == IDX_LINE_STAT |=> s_axi_rdata_out[3:0] ==
		loop_decode($past(q.sync2[SY_SENSE_LO +: 5]), $past(q.sync2[SY_HOOK])))
		else $error("loop current decode mismatch");
	a_ro_write_kept: assert property (wr_en && q.aw_idx == IDX_SYS_REV |=>
		$stable(q.ctrl_two) && $stable(q.srate))
		else $error("write to read-only register changed state");
	a_write_resp: assert property (wr_fire |=> s_axi_bvalid_out)
		else $error("write not answered");
	a_irq_level: assert property (irq_out == |(q.irq_stat & q.irq_mask))
		else $error("interrupt level mismatch");
	a_rate_sel_follow: assert property (wr_en && q.aw_idx == IDX_SRATE |=>
		sample_rate_sel_out == $past(q.w_byte[2:0]))
		else $error("sample rate select not following write");
	a_rate_rsvd_zero: assert property (sample_rate_sel_out == 3'h7 |->
		sample_rate_hz_out == 14'h0000)
		else $error("reserved sample rate code not refused");
	a_srate_rsvd_bits: assert property (rd_fire && ar_idx == IDX_SRATE |=>
		s_axi_rdata_out[7:3] == 5'h00)
		else $error("reserved sample rate bits read nonzero");
	a_ctrl_rsvd_bits: assert property (rd_fire && ar_idx == IDX_CTRL_TWO |=>
		s_axi_rdata_out[7] == 1'b0 && s_axi_rdata_out[2] == 1'b0)
		else $error("reserved control bits read nonzero");
	a_sys_rev_read: assert property (rd_fire && ar_idx == IDX_SYS_REV |=>
		s_axi_rdata_out[7:0] == {4'h0, SYS_REV_CODE})
		else $error("system-side revision read wrong");
	a_cap_read: assert property (s_line_rev_read |=> s_axi_rdata_out[7] == 1'b0 &&
		s_axi_rdata_out[6] == $past(q.sync2[SY_CAP]))
		else $error("capability bit read wrong");
	a_line_rev_read: assert property (s_line_rev_read |=>
		s_axi_rdata_out[5:2] == $past(q.sync2[SY_REV_LO +: 4]))
		else $error("line-side revision read wrong");
	a_legacy_read: assert property (s_line_rev_read |=>
		s_axi_rdata_out[1:0] == $past({q.rxb, q.txb}))
		else $error("legacy gain bits read wrong");
	a_legacy_rx: assert property (s_line_rev_write |=>
		legacy_rx_boost_out == $past(q.w_byte[LR_RXB_BIT]))
		else $error("legacy receive gain not following write");
	a_legacy_tx: assert property (s_line_rev_write |=>
		legacy_tx_atten_out == $past(q.w_byte[LR_TXB_BIT]))
		else $error("legacy transmit attenuation not following write");
	a_sync_two_stage: assert property (q.sync2 == $past(q.sync1))
		else $error("status synchroniser skipped a stage");
	a_bvalid_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
		s_axi_bvalid_out && $stable(s_axi_bresp_out))
		else $error("write response dropped before bready");
	a_rvalid_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
		s_axi_rvalid_out && $stable(s_axi_rdata_out) && $stable(s_axi_rresp_out))
		else $error("read response dropped before rready");
	a_unmapped_read: assert property (s_axi_rvalid_out && !idx_mapped(q.rd_idx) |->
		s_axi_rdata_out == 32'h0000_0000 && s_axi_rresp_out == RESP_SLVERR)
		else $error("unmapped read not refused");
	a_aw_refused: assert property (s_axi_bvalid_out |->
		!s_axi_awready_out && !s_axi_wready_out)
		else $error("write channel open while response pending");
	a_irq_stat_clear: assert property (rd_fire && ar_idx == IDX_IRQ_STAT &&
		!q.sync2[SY_LINK] && q.sync2[SY_LOCK] == q.lock_prev |=> q.irq_stat == 2'h0)
		else $error("interrupt status not cleared by read");
	a_lock_event: assert property (q.sync2[SY_LOCK] != q.lock_prev |=>
		q.irq_stat[IRQ_LOCK_CHG])
		else $error("frame lock change not recorded");
endmodule

`default_nettype wire

// ### bench/dsr_line_model.sv
`timescale 1ns/1ns
`default_nettype none

// isolated line-side chip; its status only moves on a clock edge or an asynchronous reset, like the real link
// command packing: fail, lock, hook, capability, sense[4:0], revision[3:0]
module dsr_line_model (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic [12:0] cmd_in,
	output logic link_fail_out,
	output logic frame_lock_out,
	output logic off_hook_out,
	output logic capability_out,
	output logic [4:0] sense_out,
	output logic [3:0] rev_out
);
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			{link_fail_out, frame_lock_out, off_hook_out, capability_out, sense_out, rev_out} <= '0;
		end else begin
			{link_fail_out, frame_lock_out, off_hook_out, capability_out, sense_out, rev_out} <= cmd_in;
		end
	end
endmodule

`default_nettype wire

// ### bench/daa_system_side_control_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none

module daa_system_side_control_regs_tb;
	import dsr_pkg::*;
	logic clock_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [6:0] awaddr = 7'h00;
	logic [6:0] araddr = 7'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, link_fail, frame_lock, off_hook, cap;
	logic [1:0] bresp, rresp, resp;
	logic [31:0] rdata, d;
	logic [4:0] sense;
	logic [3:0] rev;
	logic [12:0] cmd = 13'h0000;
	logic [12:0] c;
	logic tx_mute, rx_mute, line_pd, sys_pd, rx_boost, tx_att, irq;
	logic [5:0] tx_db, rx_db;
	logic [2:0] rsel;
	logic [13:0] rhz;
	logic [7:0] v;
	logic [1:0] t, x, b;
	logic [5:0] txdb [4] = '{6'h1a, 6'h14, 6'h00, 6'h20};
	logic [5:0] rxdb [4] = '{6'h06, 6'h00, 6'h00, 6'h0c};
	logic [13:0] hz [8] = '{14'h1c20, 14'h1f40, 14'h2025, 14'h20d0, 14'h2328, 14'h2580,
		14'h282e, 14'h0000};
	logic [6:0] rsv [4] = '{7'h1c, 7'h20, 7'h28, 7'h2c};
	int fail_count = 0, checks_done = 0, seed = 22398, i;

	always #20 clock_in = ~clock_in;

	dsr_line_model line (.clock_in(clock_in), .rst_n_in(rst_n_in), .cmd_in(cmd),
		.link_fail_out(link_fail), .frame_lock_out(frame_lock), .off_hook_out(off_hook),
		.capability_out(cap), .sense_out(sense), .rev_out(rev));

	// revision parameter value is arbitrary
	dsr_regs #(.SYS_REV_CODE(4'h9)) dut (.clock_in(clock_in), .rst_n_in(rst_n_in),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'h1), .s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
		.s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
		.s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
		.s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
		.link_fail_in(link_fail), .frame_lock_in(frame_lock), .off_hook_in(off_hook),
		.line_capability_in(cap), .line_sense_code_in(sense), .line_rev_code_in(rev),
		.cp_tx_mute_out(tx_mute), .cp_tx_atten_db_out(tx_db), .cp_rx_mute_out(rx_mute),
		.cp_rx_atten_db_out(rx_db), .line_chip_powerdown_out(line_pd),
		.system_module_powerdown_out(sys_pd), .sample_rate_sel_out(rsel),
		.sample_rate_hz_out(rhz), .legacy_rx_boost_out(rx_boost),
		.legacy_tx_atten_out(tx_att), .irq_out(irq));

	function automatic logic [3:0] exp_loop(input logic [4:0] code, input logic hook);
		if (hook && code == 5'h1e) return 4'he;
		if (hook && code == 5'h01) return 4'h1;
		return code[4:1];
	endfunction

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// each valid is held until its own ready edge; bready stays up until bvalid
	task automatic wr(input logic [6:0] a, input logic [7:0] dv, output logic [1:0] r);
		int n;
		awaddr <= a;
		wdata <= {24'h00_0000, dv};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge clock_in);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		if (n == 64) begin
			fail_count++;
			report_and_stop();
		end
		r = bresp;
		bready <= 1'b0;
		@(posedge clock_in);
	endtask

	task automatic rd(input logic [6:0] a, output logic [31:0] dv, output logic [1:0] r);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge clock_in);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		if (n == 64) begin
			fail_count++;
			report_and_stop();
		end
		dv = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge clock_in);
	endtask

	task automatic rchk(input string nm, input logic [6:0] a, input logic [7:0] e);
		logic [31:0] dv;
		logic [1:0] r;
		rd(a, dv, r);
		chk(nm, dv, {24'h00_0000, e});
		chk("rresp", r, RESP_OKAY);
	endtask

	initial begin
		repeat (8) @(posedge clock_in);
		rst_n_in <= 1'b1;
		@(posedge clock_in);
		chk("tx_mute", tx_mute, 1'b1);
		chk("line_pd", line_pd, 1'b1);
		rchk("ctrl", 7'h18, 8'h70);
		// rate programmed before the line chip powerdown is cleared
		for (i = 0; i < 8; i++) begin
			wr(7'h24, {5'h1f, i[2:0]}, resp);
			rchk("srate", 7'h24, {5'h00, i[2:0]});
			chk("rate_hz", rhz, hz[i]);
			chk("rate_sel", rsel, i[2:0]);
		end
		// leave a valid rate in place before bit 4 may clear
		wr(7'h24, 8'h01, resp);
		for (i = 0; i < 16; i++) begin
			t = i[3:2];
			x = i[1:0];
			v = {1'b1, t[1], x[1], 1'($random(seed)), 1'b0, 1'b1, t[0], x[0]};
			wr(7'h18, v, resp);
			rchk("ctrl", 7'h18, v & 8'h7b);
			chk("tx_mute", tx_mute, t == 2'h2);
			chk("tx_db", tx_db, txdb[t]);
			chk("rx_mute", rx_mute, x == 2'h2);
			chk("rx_db", rx_db, rxdb[x]);
			chk("line_pd", line_pd, v[4]);
		end
		foreach (rsv[k]) begin
			wr(rsv[k], 8'hff, resp);
			rchk("rsvd", rsv[k], (k == 3) ? 8'h09 : 8'h00);
		end
		wr(7'h7c, 8'hff, resp);
		chk("bresp", resp, RESP_SLVERR);
		rd(7'h7c, d, resp);
		chk("unmapped", d, 32'h0000_0000);
		chk("rresp", resp, RESP_SLVERR);
		for (i = 0; i < 12; i++) begin
			c = 13'($random(seed));
			c[12] = 1'b0;
			if (i < 4) begin
				c[10] = ~i[1];
				c[8:4] = i[0] ? 5'h01 : 5'h1e;
			end
			cmd <= c;
			repeat (6) @(posedge clock_in);
			rchk("status", 7'h30, {1'b0, c[11], 2'b00, exp_loop(c[8:4], c[10])});
			b = 2'($random(seed));
			wr(7'h34, {6'h3f, b}, resp);
			rchk("line_rev", 7'h34, {1'b0, c[9], c[3:0], b});
			chk("legacy", {rx_boost, tx_att}, b);
		end
		wr(7'h44, 8'h01, resp);
		rd(7'h40, d, resp);
		cmd <= c | 13'h1000;
		repeat (6) @(posedge clock_in);
		cmd <= c;
		repeat (6) @(posedge clock_in);
		chk("irq", irq, 1'b1);
		wr(7'h30, 8'hc0, resp);
		rchk("status", 7'h30, {1'b1, c[11], 2'b00, exp_loop(c[8:4], c[10])});
		rd(7'h40, d, resp);
		chk("irq_stat", d[0], 1'b1);
		repeat (2) @(posedge clock_in);
		chk("irq", irq, 1'b0);
		wr(7'h30, 8'h00, resp);
		rchk("status", 7'h30, {1'b0, c[11], 2'b00, exp_loop(c[8:4], c[10])});
		wr(7'h18, 8'h78, resp);
		repeat (2) @(posedge clock_in);
		chk("sys_pd", sys_pd, 1'b1);
		wr(7'h18, 8'h70, resp);
		repeat (2) @(posedge clock_in);
		chk("sys_pd", sys_pd, 1'b1);
		rst_n_in <= 1'b0;
		repeat (3) @(posedge clock_in);
		chk("sys_pd", sys_pd, 1'b0);
		rst_n_in <= 1'b1;
		@(posedge clock_in);
		rchk("ctrl", 7'h18, 8'h70);
		report_and_stop();
	end
endmodule

`default_nettype wire
